// [adcdc_chain.sv]
// Daisy-chain serial readout of a sampling converter, device side
`timescale 1ns/1ps

// How it works
// - Chain input low with convert strobe low forces the chain output low.
// - Strobe rise with chain input and shift clock low starts plain chain conversion.
// - Strobe rise with chain input low, shift clock high starts conversion with indicator.
// - Without indicator, result MSB appears on the output when conversion ends.
// - After conversion the converter powers down; shift logic stays alive.
// - Each shift clock falling edge moves the result one place toward the output.
// - Chain input enters the shift register on that same falling edge, except the first edge with indicator.
// - Every device sends its own word MSB first, then passes upstream words on.
// - Without indicator, output drops low after edge 16N or a new strobe rise.
// - With indicator, a CHAIN_HEAD device drives output high once its own conversion is done; others follow chain input.
// - With indicator, output drops low after edge 16N+1 or a new strobe rise.
// - Output stays valid over both shift clock edges; falling-edge sampling preferred.
module adcdc_chain #(
    parameter int WORD_W      = adcdc_pkg::WORD_W,
    parameter int FIFO_DEPTH  = adcdc_pkg::FIFO_DEPTH,
    parameter int CHAIN_LEN   = adcdc_pkg::CHAIN_LEN,
    parameter int CONV_CYCLES = adcdc_pkg::CONV_CYCLES,
    parameter bit CHAIN_HEAD  = 1'b1
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              shift_clk,
    input  wire logic              convert_strobe,
    input  wire logic              chain_data_in,
    input  wire logic [WORD_W-1:0] result_data,
    input  wire logic              result_valid,
    output logic                   result_ready,
    output logic                   chain_data_out,
    output logic                   converter_on
);
    localparam int CNT_W  = $clog2(WORD_W * CHAIN_LEN + 2);
    localparam int TMR_W  = $clog2(CONV_CYCLES + 1);
    localparam int MSB    = WORD_W - 1;
    localparam logic [CNT_W-1:0] LIM_PLAIN = CNT_W'(WORD_W * CHAIN_LEN);
    localparam logic [CNT_W-1:0] LIM_BUSY  = CNT_W'(WORD_W * CHAIN_LEN + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD  = TMR_W'(CONV_CYCLES - 1);

    // Pin synchronisers on mclk
    logic [adcdc_pkg::PIN_CNT-1:0] pin_raw;
    logic [adcdc_pkg::PIN_CNT-1:0] pin_meta_r;
    logic [adcdc_pkg::PIN_CNT-1:0] pin_meta_nxt;
    logic [adcdc_pkg::PIN_CNT-1:0] pin_sync_r;
    logic [adcdc_pkg::PIN_CNT-1:0] pin_sync_nxt;
    logic                          strb_prev_r;
    logic                          strb_prev_nxt;
    logic                          strb_s;
    logic                          din_s;
    logic                          sck_s;
    logic                          strb_rise;

    assign pin_raw[adcdc_pkg::PIN_STRB] = convert_strobe;
    assign pin_raw[adcdc_pkg::PIN_DIN]  = chain_data_in;
    assign pin_raw[adcdc_pkg::PIN_SCK]  = shift_clk;

    always_comb begin
        pin_meta_nxt  = pin_raw;
        pin_sync_nxt  = pin_meta_r;
        strb_prev_nxt = pin_sync_r[adcdc_pkg::PIN_STRB];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_r  <= '0;
            pin_sync_r  <= '0;
            strb_prev_r <= 1'b0;
        end else begin
            pin_meta_r  <= pin_meta_nxt;
            pin_sync_r  <= pin_sync_nxt;
            strb_prev_r <= strb_prev_nxt;
        end
    end

    assign strb_s    = pin_sync_r[adcdc_pkg::PIN_STRB];
    assign din_s     = pin_sync_r[adcdc_pkg::PIN_DIN];
    assign sck_s     = pin_sync_r[adcdc_pkg::PIN_SCK];
    assign strb_rise = strb_s && !strb_prev_r;

    // Result FIFO
    logic [WORD_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic              fifo_room;

    adcdc_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (mclk),
        .rstn      (rstn),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (fifo_room),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // Conversion control on mclk
    adcdc_pkg::adcdc_state_e state_r;
    adcdc_pkg::adcdc_state_e state_nxt;
    logic [TMR_W-1:0]        tmr_r;
    logic [TMR_W-1:0]        tmr_nxt;
    logic                    busy_en_r;
    logic                    busy_en_nxt;
    logic [WORD_W-1:0]       word_r;
    logic [WORD_W-1:0]       word_nxt;
    logic                    link_hold_r;
    logic                    link_hold_nxt;
    logic                    conv_on_r;
    logic                    conv_on_nxt;
    logic                    start_ok;

    // Strobe rise with chain input low selects chain mode; high would be the
    // chip-select modes, which this block does not carry.
    assign start_ok = strb_rise && !din_s;

    always_comb begin
        state_nxt     = state_r;
        tmr_nxt       = tmr_r;
        busy_en_nxt   = busy_en_r;
        word_nxt      = word_r;
        link_hold_nxt = link_hold_r;
        conv_on_nxt   = conv_on_r;
        fifo_pop      = 1'b0;
        if (start_ok) begin
            // A new strobe rise aborts any readback in progress
            state_nxt     = adcdc_pkg::ADCDC_CONV;
            tmr_nxt       = TMR_LOAD;
            busy_en_nxt   = sck_s;
            link_hold_nxt = 1'b1;
            conv_on_nxt   = 1'b1;
        end else begin
            case (state_r)
                adcdc_pkg::ADCDC_IDLE: begin
                    link_hold_nxt = 1'b1;
                end
                adcdc_pkg::ADCDC_CONV: begin
                    // Strobe level is ignored until the timer runs out
                    if (tmr_r == '0) begin
                        state_nxt = adcdc_pkg::ADCDC_FETCH;
                    end else begin
                        tmr_nxt = TMR_W'(tmr_r - 1'b1);
                    end
                end
                adcdc_pkg::ADCDC_FETCH: begin
                    // Waits here if the converter has not delivered a word yet
                    if (fifo_valid) begin
                        fifo_pop      = 1'b1;
                        word_nxt      = fifo_data;
                        state_nxt     = adcdc_pkg::ADCDC_READ;
                        link_hold_nxt = 1'b0;
                        conv_on_nxt   = 1'b0;
                    end
                end
                adcdc_pkg::ADCDC_READ: begin
                    link_hold_nxt = 1'b0;
                end
                default: begin
                    state_nxt     = adcdc_pkg::ADCDC_IDLE;
                    link_hold_nxt = 1'b1;
                    conv_on_nxt   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= adcdc_pkg::ADCDC_IDLE;
            tmr_r       <= '0;
            busy_en_r   <= 1'b0;
            word_r      <= '0;
            link_hold_r <= 1'b1;
            conv_on_r   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            tmr_r       <= tmr_nxt;
            busy_en_r   <= busy_en_nxt;
            word_r      <= word_nxt;
            link_hold_r <= link_hold_nxt;
            conv_on_r   <= conv_on_nxt;
        end
    end

    // Shift logic on the shift clock
    // Held in reset from mclk while converting, so it starts clean on the
    // first falling edge of each readback. word_r and busy_en_r are static
    // whenever the hold is released, which makes reading them here safe.
    logic              link_rst_n;
    logic [WORD_W-1:0] sreg_r;
    logic [WORD_W-1:0] sreg_nxt;
    logic [CNT_W-1:0]  edge_cnt_r;
    logic [CNT_W-1:0]  edge_cnt_nxt;
    logic              started_r;
    logic              started_nxt;
    logic              lnk_bit_r;
    logic              lnk_bit_nxt;
    logic [WORD_W-1:0] shift_src;
    logic [CNT_W-1:0]  edge_lim;

    assign link_rst_n = rstn && !link_hold_r;
    assign edge_lim   = busy_en_r ? LIM_BUSY : LIM_PLAIN;

    always_comb begin
        shift_src = started_r ? sreg_r : word_r;
        if (busy_en_r && !started_r) begin
            // First edge only drops the start bit; the upstream start bit is discarded
            sreg_nxt = word_r;
        end else begin
            sreg_nxt = {shift_src[MSB-1:0], chain_data_in};
        end
        edge_cnt_nxt = (edge_cnt_r == edge_lim) ? edge_cnt_r : CNT_W'(edge_cnt_r + 1'b1);
        lnk_bit_nxt  = (edge_cnt_nxt == edge_lim) ? adcdc_pkg::OUT_IDLE : sreg_nxt[MSB];
        started_nxt  = 1'b1;
    end

    always_ff @(negedge shift_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sreg_r     <= '0;
            edge_cnt_r <= '0;
            started_r  <= 1'b0;
            lnk_bit_r  <= 1'b0;
        end else begin
            sreg_r     <= sreg_nxt;
            edge_cnt_r <= edge_cnt_nxt;
            started_r  <= started_nxt;
            lnk_bit_r  <= lnk_bit_nxt;
        end
    end

    // Link to mclk crossing
    logic [1:0] lnk_meta_r;
    logic [1:0] lnk_meta_nxt;
    logic [1:0] lnk_sync_r;
    logic [1:0] lnk_sync_nxt;
    logic       started_d_r;
    logic       started_d_nxt;

    always_comb begin
        lnk_meta_nxt  = {started_r, lnk_bit_r};
        lnk_sync_nxt  = lnk_meta_r;
        // Extra stage lets the data bit settle before it is selected
        started_d_nxt = lnk_sync_r[1];
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lnk_meta_r  <= '0;
            lnk_sync_r  <= '0;
            started_d_r <= 1'b0;
        end else begin
            lnk_meta_r  <= lnk_meta_nxt;
            lnk_sync_r  <= lnk_sync_nxt;
            started_d_r <= started_d_nxt;
        end
    end

    // Chain output and status
    // Output is one mclk flop, so it trails a falling edge by up to
    // four mclk cycles; a host sampling on the next falling edge sees it.
    logic dout_r;
    logic dout_nxt;
    logic ready_r;
    logic ready_nxt;

    always_comb begin
        dout_nxt  = adcdc_pkg::OUT_IDLE;
        ready_nxt = fifo_room;
        if (!strb_s && !din_s) begin
            dout_nxt = adcdc_pkg::OUT_IDLE;
        end else if (state_r == adcdc_pkg::ADCDC_READ && !start_ok) begin
            if (started_d_r) begin
                dout_nxt = lnk_sync_r[0];
            end else if (busy_en_r) begin
                // CHAIN_HEAD device rises once its own word is ready; others rise only once the upstream neighbour is done
                dout_nxt = CHAIN_HEAD ? adcdc_pkg::BUSY_LEVEL : din_s;
            end else begin
                dout_nxt = word_r[MSB];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dout_r  <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            dout_r  <= dout_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign chain_data_out = dout_r;
    assign converter_on   = conv_on_r;
    assign result_ready   = ready_r;
endmodule

// [adcdc_pkg.sv]
// Shared constants for the daisy-chain converter readout block
package adcdc_pkg;
    localparam int          WORD_W        = 16;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          CHAIN_LEN     = 1;
    localparam int          MCLK_HZ       = 40_000_000;
    localparam int          CONV_TIME_NS  = 2200;
    // Least time, so round up to whole cycles, never below one
    localparam int          CONV_CYC_RAW  = (CONV_TIME_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          CONV_CYCLES   = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
    localparam int          SYNC_STAGES   = 2;
    localparam logic        OUT_IDLE      = 1'b0;
    localparam logic        BUSY_LEVEL    = 1'b1;
    // Index of each synchronised pin in the pin synchroniser vectors
    localparam int          PIN_STRB      = 0;
    localparam int          PIN_DIN       = 1;
    localparam int          PIN_SCK       = 2;
    localparam int          PIN_CNT       = 3;

    typedef enum logic [1:0] {
        ADCDC_IDLE,
        ADCDC_CONV,
        ADCDC_FETCH,
        ADCDC_READ
    } adcdc_state_e;
endpackage

// [adcdc_fifo.sv]
// Result word FIFO with registered full and empty flags
`timescale 1ns/1ps
module adcdc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          full_r;
    logic          full_nxt;
    logic          empty_r;
    logic          empty_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid && !full_r;
    assign pop       = out_ready && !empty_r;
    assign in_ready  = !full_r;
    assign out_valid = !empty_r;
    assign out_data  = mem[rd_ptr_r];

    always_comb begin
        wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        count_nxt  = count_r;
        if (push && !pop) begin
            count_nxt = CW'(count_r + 1'b1);
        end else if (pop && !push) begin
            count_nxt = CW'(count_r - 1'b1);
        end
        full_nxt  = (count_nxt == FULL_CNT);
        empty_nxt = (count_nxt == '0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            full_r   <= 1'b0;
            empty_r  <= 1'b1;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            full_r   <= full_nxt;
            empty_r  <= empty_nxt;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule

// [adcdc_assertions.sv]
// Port-level assertions for the daisy-chain readout
`timescale 1ns/1ps
module adcdc_assertions #(
    parameter int CONV_CYCLES = 4
) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        shift_clk,
    input wire logic        convert_strobe,
    input wire logic        chain_data_in,
    input wire logic [15:0] result_data,
    input wire logic        result_valid,
    input wire logic        result_ready,
    input wire logic        chain_data_out,
    input wire logic        converter_on
);
    logic       ind_r;
    logic [7:0] on_cnt_r;
    // Mode is taken from the shift clock level at the strobe rise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ind_r    <= 1'b0;
            on_cnt_r <= 8'h00;
        end else begin
            if ($rose(convert_strobe) && !converter_on)
                ind_r <= shift_clk;
            on_cnt_r <= converter_on ? on_cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_low_when_idle: assert property ((!convert_strobe && !chain_data_in) [*4] |-> !chain_data_out)
        else $error("output not low while idle");
    a_start_conv: assert property ($rose(convert_strobe) && !chain_data_in && !converter_on |-> ##[2:5] converter_on)
        else $error("strobe rise did not start");
    a_ignore_high_in: assert property ($rose(convert_strobe) && chain_data_in && !converter_on |=> !converter_on [*6])
        else $error("start with chain input high");
    a_conv_length: assert property ($fell(converter_on) |-> on_cnt_r >= CONV_CYCLES)
        else $error("conversion too short");
    a_busy_high: assert property ($fell(converter_on) && ind_r |-> ##[0:3] chain_data_out)
        else $error("indicator not raised");
    a_rise_clears: assert property ($rose(convert_strobe) && !chain_data_in |-> ##[1:5] !chain_data_out)
        else $error("strobe rise did not clear output");
    a_quiet_conv: assert property (converter_on && $past(converter_on) |-> !chain_data_out)
        else $error("output active while converting");
    a_start_cause: assert property ($rose(converter_on) |-> $past(convert_strobe, 2) && !$past(chain_data_in, 2))
        else $error("conversion without strobe");
endmodule

// [adcdc_host.sv]
// Host model: strobe, shift clock and the upstream chain bits
`timescale 1ns/1ps
module adcdc_host (
    input  wire logic mclk,
    input  wire logic chain_data_out,
    output logic      convert_strobe,
    output logic      shift_clk,
    output logic      chain_data_in
);
    logic [40:0] bits;
    initial begin
        convert_strobe = 1'b0;
        shift_clk      = 1'b0;
        chain_data_in  = 1'b0;
    end
    task automatic start(input logic ind);
        @(negedge mclk);
        shift_clk     <= ind;
        chain_data_in <= 1'b0;
        repeat (4) @(negedge mclk);
        convert_strobe <= 1'b1;
    endtask
    task automatic refuse();
        @(negedge mclk);
        chain_data_in <= 1'b1;
        repeat (4) @(negedge mclk);
        convert_strobe <= 1'b1;
        repeat (10) @(negedge mclk);
    endtask
    task automatic stop();
        @(negedge mclk);
        convert_strobe <= 1'b0;
        shift_clk      <= 1'b0;
        chain_data_in  <= 1'b0;
    endtask
    // Off the mclk grid; sampled just before each fall, where the bit has stood longest
    task automatic frame(input int n, input logic [15:0] up, input logic ind);
        #3.7;
        // A busy upstream neighbour shows its start bit before the first fall
        chain_data_in = ind ? 1'b1 : up[15];
        for (int k = 0; k < n; k++) begin
            shift_clk = 1'b1;
            #62.5;
            bits[k]   = chain_data_out;
            shift_clk = 1'b0;
            // Upstream output changes after the fall, never with it
            #10;
            chain_data_in = (k + 1 - int'(ind) < 16) ? up[14 - k + int'(ind)] : 1'b0;
            #52.5;
        end
    endtask
endmodule

// [adcdc_tb.sv]
// Self-checking bench for the daisy-chain readout
`timescale 1ns/1ps
module testbench;
    logic        mclk;
    logic        rstn;
    logic        shift_clk;
    logic        convert_strobe;
    logic        chain_data_in;
    logic [15:0] result_data;
    logic        result_valid;
    logic        result_ready;
    logic        chain_data_out;
    logic        converter_on;
    int          error_cnt;
    int          checks;
    logic [31:0] seed;
    logic [15:0] words[$];
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    adcdc_chain #(.CHAIN_LEN(2), .CONV_CYCLES(4)) i_adcdc_chain (.mclk(mclk), .rstn(rstn),
        .shift_clk(shift_clk), .convert_strobe(convert_strobe), .chain_data_in(chain_data_in),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .chain_data_out(chain_data_out), .converter_on(converter_on));
    adcdc_host i_adcdc_host (.mclk(mclk), .chain_data_out(chain_data_out), .convert_strobe(convert_strobe),
        .shift_clk(shift_clk), .chain_data_in(chain_data_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Bit seen before fall k: busy bit, own word, then upstream word
    function automatic logic exp_bit(input logic ind, input int k, input logic [15:0] o, input logic [15:0] u);
        int j;
        j = k - int'(ind);
        if (ind && k == 0)
            return 1'b1;
        return (j < 16) ? o[15-j] : u[31-j];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic push(input logic [15:0] d);
        @(negedge mclk);
        result_data  = d;
        result_valid = 1'b1;
        @(posedge mclk);
    endtask
    task automatic convert(input logic ind, input int n);
        int          t;
        logic [15:0] w;
        logic [15:0] up;
        seed = xs(seed);
        up   = seed[31:16];
        i_adcdc_host.start(ind);
        if (words.size() == 0) begin
            repeat (30) @(negedge mclk);
            check({15'h0000, converter_on}, 16'h0001, "left waiting");
            words.push_back(seed[15:0]);
            push(seed[15:0]);
            @(negedge mclk) result_valid = 1'b0;
        end
        w = words.pop_front();
        t = 0;
        while (t < 400 && !(t > 12 && converter_on === 1'b0)) begin
            @(negedge mclk);
            t++;
        end
        repeat (4) @(negedge mclk);
        check({15'h0000, t < 400}, 16'h0001, "no end");
        check({15'h0000, chain_data_out}, {15'h0000, ind | w[15]}, "first bit");
        check({15'h0000, converter_on}, 16'h0000, "still on");
        i_adcdc_host.frame(n, up, ind);
        for (int k = 0; k < n; k++)
            check({15'h0000, i_adcdc_host.bits[k]}, {15'h0000, exp_bit(ind, k, w, up)}, "bit");
        repeat (5) @(negedge mclk);
        if (n > 16)
            check({15'h0000, chain_data_out}, 16'h0000, "after frame");
        i_adcdc_host.stop();
        repeat (5) @(negedge mclk);
        check({15'h0000, chain_data_out}, 16'h0000, "idle");
    endtask
    initial begin
        rstn         = 1'b0;
        result_valid = 1'b0;
        result_data  = 16'h0000;
        error_cnt    = 0;
        checks       = 0;
        seed         = 32'h0000EA66;
        repeat (16) @(posedge mclk);
        @(negedge mclk) rstn = 1'b1;
        @(negedge mclk);
        check({15'h0000, result_ready}, 16'h0001, "not ready");
        i_adcdc_host.refuse();
        check({15'h0000, converter_on}, 16'h0000, "started");
        i_adcdc_host.stop();
        $display("test refuse done");
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            words.push_back(seed[15:0]);
            push(seed[15:0]);
        end
        // A seventeenth word is held up and must be refused
        push(16'hFFFF);
        repeat (3) @(posedge mclk);
        check({15'h0000, result_ready}, 16'h0000, "not full");
        @(negedge mclk) result_valid = 1'b0;
        $display("test fill done");
        for (int i = 0; i < 17; i++) begin
            convert(i[0], (i == 3) ? 5 : 32 + i[0]);
            $display("test conversion %0d done", i);
        end
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
bind adcdc_chain adcdc_assertions #(.CONV_CYCLES(CONV_CYCLES)) i_adcdc_assertions (.mclk(mclk), .rstn(rstn),
    .shift_clk(shift_clk), .convert_strobe(convert_strobe), .chain_data_in(chain_data_in),
    .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
    .chain_data_out(chain_data_out), .converter_on(converter_on));
